// file: hw/gled_regs.svh
// Register offsets, field layouts, reset values and timing figures
// for the indicator pin block.
// Assumes a 4-bit byte address on the register bus and 32-bit data.
`ifndef GLED_REGS_SVH
`define GLED_REGS_SVH

`define GLED_ADDR_W 4
`define GLED_NPIN 3
`define GLED_CFG_W 6
`define GLED_TMR_W 24

`define GLED_CFG_OFFS 4'h0
`define GLED_DOUT_OFFS 4'h4
`define GLED_STAT_OFFS 4'h8

`define GLED_CFG_RST 6'h00
`define GLED_DOUT_RST 3'h0
`define GLED_IND_RST 3'h7

`define GLED_RESP_OKAY 2'h0
`define GLED_RESP_SLVERR 2'h2

`define GLED_BLINK_MS 80
`define GLED_CLK_KHZ 125000

`endif

// file: hw/gled_pkg.sv
// Types shared by the indicator pin block.
// Assumes gled_regs.svh is on the include path.
`include "gled_regs.svh"
`default_nettype none

package gled_pkg;

    // Function of one pin, two configuration bits per pin.
    typedef enum logic [1:0] {
        MODE_IN = 2'b00,
        MODE_PP = 2'b01,
        MODE_OD = 2'b10,
        MODE_LED = 2'b11
    } gled_mode_t;

    // Phase of the activity blink.
    typedef enum logic [1:0] {
        BLK_ON = 2'b00,
        BLK_OFF = 2'b01,
        BLK_HOLD = 2'b10
    } gled_blink_t;

    // Whole state of the block.
    typedef struct packed {
        logic [`GLED_CFG_W-1:0] cfg;
        logic [`GLED_NPIN-1:0] dout;
        logic aw_got;
        logic w_got;
        logic [`GLED_ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        gled_blink_t blink;
        logic [`GLED_TMR_W-1:0] timer;
        logic [`GLED_NPIN-1:0] ind_n;
        logic [`GLED_NPIN-1:0] pin_out;
        logic [`GLED_NPIN-1:0] pin_oe;
    } gled_state_t;

endpackage

`default_nettype wire

// file: hw/gled_top.sv
// Three multipurpose pins: input, push-pull, open-drain or status LED,
// with an AXI4-Lite register slave.
// Assumes link state inputs come synchronous to ref_clk from the PHY.
// Operation
// - Each pin: push-pull, open-drain or input.
// - LED mode also selectable; drives open-drain.
// - Speed LED low unless 10 Mb/s link; code also holds it low while autoneg_busy.
// - Link LED low on link, no blink.
// - Activity on link blinks LED off 80 ms.
// - After blink, stay on at least 80 ms.
// - Duplex LED low when full duplex.
`include "gled_regs.svh"
`default_nettype none

module gled_top #(
    parameter int unsigned BLINK_CYCLES =
        `GLED_BLINK_MS * `GLED_CLK_KHZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`GLED_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [`GLED_ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic link_up,
    input wire logic speed_100,
    input wire logic autoneg_busy,
    input wire logic full_duplex,
    input wire logic tx_activity,
    input wire logic rx_activity,
    input wire logic [`GLED_NPIN-1:0] indicator_pins_in,
    output logic [`GLED_NPIN-1:0] indicator_pins_out,
    output logic [`GLED_NPIN-1:0] indicator_pins_oe,
    output logic speed_indicator_n,
    output logic link_activity_indicator_n,
    output logic duplex_indicator_n
);
    import gled_pkg::*;

    // Last count of an 80 ms interval; the timer runs 0 to this value.
    localparam logic [`GLED_TMR_W-1:0] TMR_LAST =
        `GLED_TMR_W'(BLINK_CYCLES - 1);

    gled_state_t r_reg;
    gled_state_t r_next;
    gled_mode_t pin_mode;
    logic act;

    // Channels accept only while their half of a write is still missing
    // and no response is pending, so one write is under way at a time.
    assign awready = !r_reg.aw_got && !r_reg.bvalid;
    assign wready = !r_reg.w_got && !r_reg.bvalid;
    assign arready = !r_reg.rvalid;

    // Outputs straight from the state register.
    assign bvalid = r_reg.bvalid;
    assign bresp = r_reg.bresp;
    assign rvalid = r_reg.rvalid;
    assign rdata = r_reg.rdata;
    assign rresp = r_reg.rresp;
    assign indicator_pins_out = r_reg.pin_out;
    assign indicator_pins_oe = r_reg.pin_oe;
    assign speed_indicator_n = r_reg.ind_n[0];
    assign link_activity_indicator_n = r_reg.ind_n[1];
    assign duplex_indicator_n = r_reg.ind_n[2];

    // Next-state logic for bus slave, blink timer and pin drivers.
    always_comb begin
        r_next = r_reg;
        pin_mode = MODE_IN;
        act = tx_activity | rx_activity;

        // Write address and data are caught in either order.
        if (awvalid && awready) begin
            r_next.aw_got = 1'b1;
            r_next.waddr = awaddr;
        end
        if (wvalid && wready) begin
            r_next.w_got = 1'b1;
            r_next.wdata = wdata;
            r_next.wstrb = wstrb;
        end
        if (r_reg.bvalid && bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = `GLED_RESP_OKAY;
            case (r_reg.waddr)
                `GLED_CFG_OFFS: begin
                    if (r_reg.wstrb[0]) begin
                        r_next.cfg = r_reg.wdata[`GLED_CFG_W-1:0];
                    end
                end
                `GLED_DOUT_OFFS: begin
                    if (r_reg.wstrb[0]) begin
                        r_next.dout = r_reg.wdata[`GLED_NPIN-1:0];
                    end
                end
                `GLED_STAT_OFFS: begin
                    r_next.bresp = `GLED_RESP_OKAY;
                end
                default: begin
                    r_next.bresp = `GLED_RESP_SLVERR;
                end
            endcase
        end

        // Reads answer one cycle after the address is taken.
        if (arvalid && arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = `GLED_RESP_OKAY;
            case (araddr)
                `GLED_CFG_OFFS: begin
                    r_next.rdata = {26'h0000000, r_reg.cfg};
                end
                `GLED_DOUT_OFFS: begin
                    r_next.rdata = {29'h00000000, r_reg.dout};
                end
                `GLED_STAT_OFFS: begin
                    r_next.rdata = {25'h0000000, r_reg.ind_n, 1'b0,
                        indicator_pins_in};
                end
                default: begin
                    r_next.rdata = 32'h00000000;
                    r_next.rresp = `GLED_RESP_SLVERR;
                end
            endcase
        end else if (r_reg.rvalid && rready) begin
            r_next.rvalid = 1'b0;
        end

        // Activity blink: off for one interval, then a forced on
        // interval so that steady traffic still shows as a visible flash.
        case (r_reg.blink)
            BLK_ON: begin
                if (link_up && act) begin
                    r_next.blink = BLK_OFF;
                    r_next.timer = '0;
                end
            end
            BLK_OFF: begin
                if (r_reg.timer == TMR_LAST) begin
                    r_next.blink = BLK_HOLD;
                    r_next.timer = '0;
                end else begin
                    r_next.timer = r_reg.timer + 1'b1;
                end
            end
            BLK_HOLD: begin
                if (r_reg.timer == TMR_LAST) begin
                    r_next.blink = BLK_ON;
                end else begin
                    r_next.timer = r_reg.timer + 1'b1;
                end
            end
            default: begin
                r_next.blink = BLK_ON;
            end
        endcase
        // A lost link abandons any blink in progress.
        if (!link_up) begin
            r_next.blink = BLK_ON;
            r_next.timer = '0;
        end

        // Indicator levels, all active low toward the LED.
        r_next.ind_n[0] = link_up & ~speed_100 & ~autoneg_busy;
        r_next.ind_n[1] = ~(link_up & (r_next.blink != BLK_OFF));
        r_next.ind_n[2] = ~(link_up & full_duplex);

        // Pin drivers; LED mode never drives high so the LED can sit
        // on a different supply than the pad.
        for (int i = 0; i < `GLED_NPIN; i++) begin
            pin_mode = gled_mode_t'(r_next.cfg[2*i +: 2]);
            case (pin_mode)
                MODE_PP: begin
                    r_next.pin_out[i] = r_next.dout[i];
                    r_next.pin_oe[i] = 1'b1;
                end
                MODE_OD: begin
                    r_next.pin_out[i] = 1'b0;
                    r_next.pin_oe[i] = ~r_next.dout[i];
                end
                MODE_LED: begin
                    r_next.pin_out[i] = 1'b0;
                    r_next.pin_oe[i] = ~r_next.ind_n[i];
                end
                default: begin
                    r_next.pin_out[i] = 1'b0;
                    r_next.pin_oe[i] = 1'b0;
                end
            endcase
        end
    end

    // State register; reset leaves every pin an undriven input.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.ind_n <= `GLED_IND_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_input_after_reset: assert property (
        $fell(rst) |-> indicator_pins_oe == 3'h0 && r_reg.cfg == 6'h00)
        else $error("pins not inputs after reset");

    // Reset-cycle attempts are excluded: indicators sit high in reset.
    a_speed_low: assert property (
        !rst && (speed_100 || autoneg_busy || !link_up)
        |=> !speed_indicator_n)
        else $error("speed indicator not low");

    a_speed_high: assert property (
        !rst && link_up && !speed_100 && !autoneg_busy
        |=> speed_indicator_n)
        else $error("speed indicator not high at 10 Mb/s");

    a_duplex_level: assert property (
        !rst |=> duplex_indicator_n
        == !($past(link_up) && $past(full_duplex)))
        else $error("duplex indicator wrong");

    a_link_steady_on: assert property (
        (!rst && r_reg.blink == BLK_ON && link_up
        && !(tx_activity || rx_activity))
        |=> !link_activity_indicator_n)
        else $error("link indicator not on");

    a_blink_starts: assert property (
        (!rst && r_reg.blink == BLK_ON && link_up
        && (tx_activity || rx_activity))
        |=> link_activity_indicator_n && r_reg.timer == 24'h000000)
        else $error("activity blink not started");

    a_off_ends_to_hold: assert property (
        (!rst && r_reg.blink == BLK_OFF && r_reg.timer == TMR_LAST
        && link_up)
        |=> r_reg.blink == BLK_HOLD && !link_activity_indicator_n)
        else $error("off interval did not end in hold");

    a_hold_full_length: assert property (
        (!rst && r_reg.blink == BLK_HOLD && link_up
        && r_reg.timer != TMR_LAST)
        |=> r_reg.blink == BLK_HOLD && !link_activity_indicator_n)
        else $error("hold interval cut short");

    a_led_open_drain: assert property (
        r_reg.cfg[1:0] == MODE_LED |-> !indicator_pins_out[0]
        && indicator_pins_oe[0] == !speed_indicator_n)
        else $error("led pin not open drain");

    a_push_pull: assert property (
        r_reg.cfg[3:2] == MODE_PP |-> indicator_pins_oe[1]
        && indicator_pins_out[1] == r_reg.dout[1])
        else $error("push-pull pin wrong");

    // Open drain only ever pulls low; a high data bit releases the pad.
    a_open_drain: assert property (
        r_reg.cfg[3:2] == MODE_OD |-> !indicator_pins_out[1]
        && indicator_pins_oe[1] == !r_reg.dout[1])
        else $error("open-drain pin wrong");

    // An input pin must never fight whatever drives it from outside.
    a_input_released: assert property (
        r_reg.cfg[5:4] == MODE_IN |-> !indicator_pins_oe[2])
        else $error("input pin driven");

    // A taken read address is answered at the very next edge.
    a_read_answer: assert property (
        arvalid && arready |=> rvalid)
        else $error("read response late");

    a_write_answer: assert property (
        (awvalid && awready && wvalid && wready) |=> ##1 bvalid)
        else $error("write response late");

    c_blink_cycle: cover property (
        r_reg.blink == BLK_HOLD ##1 r_reg.blink == BLK_ON);
    c_led_mode_set: cover property (r_reg.cfg == 6'h3F);
    c_read_status: cover property (rvalid && rready);
    c_open_drain_release: cover property (
        r_reg.cfg[3:2] == MODE_OD && !indicator_pins_oe[1]);
    c_ten_mb_link: cover property (link_up && speed_indicator_n);
endmodule

`default_nettype wire

// file: testbench/gled_pin_model.sv
// Board around the three indicator pins: a pull-up on every pin and an
// outside driver that the bench may switch on.
// Assumes the block drives a pin only while its enable is high.
`default_nettype none

module gled_pin_model (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // A pin that neither side drives reads high through its pull-up, never an old value.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i]) pin_level[i] = pin_out[i];
            else if (ext_en[i]) pin_level[i] = ext_val[i];
            else pin_level[i] = 1'h1;
        end
    end
endmodule

`default_nettype wire

// file: testbench/gpio_led_status_indicators_tb_top.sv
// Bench for the indicator pin block: pin modes, indicators and blink.
// Assumes gled_regs.svh on the include path; pins meet gled_pin_model.
`include "gled_regs.svh"
`default_nettype none

module gpio_led_status_indicators_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // A short blink keeps the run brief; all timing follows from it.
    localparam int BC = 8;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic link_up = 1'h0, speed_100 = 1'h0, autoneg_busy = 1'h0;
    logic full_duplex = 1'h0, tx_act = 1'h0, rx_act = 1'h0;
    logic [2:0] p_in, p_out, p_oe, ext_en = 3'h0, ext_val = 3'h0;
    logic spd_n, lnk_n, dup_n;
    int miscompares = 0;
    int checks = 0;

    always #4 ref_clk = ~ref_clk;

    gled_top #(.BLINK_CYCLES(BC)) DUT (
        .ref_clk(ref_clk), .rst(rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .link_up(link_up),
        .speed_100(speed_100), .autoneg_busy(autoneg_busy),
        .full_duplex(full_duplex), .tx_activity(tx_act),
        .rx_activity(rx_act), .indicator_pins_in(p_in),
        .indicator_pins_out(p_out), .indicator_pins_oe(p_oe),
        .speed_indicator_n(spd_n), .link_activity_indicator_n(lnk_n),
        .duplex_indicator_n(dup_n)
    );

    gled_pin_model pins (
        .pin_out(p_out), .pin_oe(p_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_level(p_in)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic timeout();
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        end_sim();
    endtask

    // Waits on falling edges, where every output has settled.
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (s !== 1'h1 && n < 50);
        if (s !== 1'h1) timeout();
    endtask

    // Address and data are offered together; each drops once taken.
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic ad, wd, ah, wh;
        ad = 1'h0;
        wd = 1'h0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (int n = 0; !(ad && wd); n++) begin
            if (n == 50) timeout();
            @(negedge ref_clk);
            ah = !ad && awready;
            wh = !wd && wready;
            @(posedge ref_clk);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
            ad |= ah;
            wd |= wh;
        end
        bready <= 1'h1;
        wait_hi(bvalid);
        check(32'(bresp), 32'(er));
        @(posedge ref_clk);
        bready <= 1'h0;
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        wait_hi(arready);
        @(posedge ref_clk);
        arvalid <= 1'h0;
        rready <= 1'h1;
        wait_hi(rvalid);
        check(rdata, ed);
        check(32'(rresp), 32'(er));
        @(posedge ref_clk);
        rready <= 1'h0;
    endtask

    task automatic t_reset();
        check(32'(p_oe), 32'h0);
        bus_rd(`GLED_CFG_OFFS, 32'h0, `GLED_RESP_OKAY);
        $display("test reset done");
    endtask

    // Pin 0 push-pull, pin 1 open-drain, pin 2 input driven from outside.
    task automatic t_gpio();
        bus_wr(`GLED_CFG_OFFS, 32'h09, `GLED_RESP_OKAY);
        bus_wr(`GLED_DOUT_OFFS, 32'h1, `GLED_RESP_OKAY);
        ext_en <= 3'h4;
        repeat (3) @(negedge ref_clk);
        check(32'(p_oe), 32'h3);
        check(32'(p_out), 32'h1);
        bus_rd(`GLED_STAT_OFFS, 32'h61, `GLED_RESP_OKAY);
        bus_wr(`GLED_DOUT_OFFS, 32'h6, `GLED_RESP_OKAY);
        ext_val <= 3'h4;
        repeat (3) @(negedge ref_clk);
        check(32'(p_oe), 32'h1);
        check(32'(p_out), 32'h0);
        bus_rd(`GLED_STAT_OFFS, 32'h66, `GLED_RESP_OKAY);
        bus_wr(4'hC, 32'h3F, `GLED_RESP_SLVERR);
        bus_rd(4'hC, 32'h0, `GLED_RESP_SLVERR);
        $display("test gpio done");
    endtask

    // Every mix of link, speed, negotiation and duplex inputs.
    task automatic t_ind();
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            @(posedge ref_clk);
            {link_up, speed_100, autoneg_busy, full_duplex} <= v;
            repeat (3) @(negedge ref_clk);
            check(32'(spd_n), 32'(v[3] && !v[2] && !v[1]));
            check(32'(dup_n), 32'(!(v[3] && v[0])));
            check(32'(lnk_n), 32'(!v[3]));
        end
        $display("test indicators done");
    endtask

    // LED mode on all pins: enable pulls low only where the LED is lit.
    task automatic t_led();
        @(posedge ref_clk);
        speed_100 <= 1'h0;
        autoneg_busy <= 1'h0;
        bus_wr(`GLED_CFG_OFFS, 32'h3F, `GLED_RESP_OKAY);
        repeat (3) @(negedge ref_clk);
        check(32'(p_oe), 32'h6);
        check(32'(p_out), 32'h0);
        $display("test led done");
    endtask

    // Activity kept up through the on phase must not shorten it.
    task automatic t_blink();
        int n;
        @(posedge ref_clk);
        tx_act <= 1'h1;
        @(posedge ref_clk);
        tx_act <= 1'h0;
        wait_hi(lnk_n);
        for (n = 1; n < 40; n++) begin
            @(negedge ref_clk);
            if (lnk_n !== 1'h1) break;
        end
        check(32'(n), 32'(BC));
        @(posedge ref_clk);
        rx_act <= 1'h1;
        for (n = 1; n < 40; n++) begin
            @(negedge ref_clk);
            if (lnk_n !== 1'h0) break;
        end
        check(32'(n >= BC && n <= BC + 2), 32'h1);
        @(posedge ref_clk);
        rx_act <= 1'h0;
        $display("test blink done");
    endtask

    // Reset in mid-run, with LED mode set and a blink under way.
    task automatic t_rst_mid();
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        @(negedge ref_clk);
        check(32'(p_oe), 32'h0);
        bus_rd(`GLED_CFG_OFFS, 32'h0, `GLED_RESP_OKAY);
        check(32'(p_oe), 32'h0);
        check(32'(lnk_n), 32'h0);
        $display("test mid-run reset done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        @(negedge ref_clk);
        t_reset();
        t_gpio();
        t_ind();
        t_led();
        t_blink();
        t_rst_mid();
        end_sim();
    end
endmodule

`default_nettype wire
